// ==== rtl/system_integration_unit.sv ====
// module: break flag protection, low-power control and reset status
`timescale 1ns/1ps
`default_nettype none
// How it works
// - in break, peripheral flag clears blocked unless break_clear_permit set
// - clears done during permitted break are real clears, they persist
// - two-step clears: second step blocked in break, works after break
// - wait or stop instruction pulses clear of the core interrupt mask
// - wait mode stops core clock, peripheral clock keeps running
// - interrupt in wait starts stacking the next cycle
// - reset or break exits wait/stop; break exit sets break_exit_flag
// - watchdog_disable low keeps watchdog running in wait
// - stop mode turns off both clock outputs
// - interrupt exits stop; stacking begins after recovery delay
// - recovery 4096 cycles, or 32 with short_recovery_select set
// - system counter held reset through stop, counts during recovery
// - break_exit_flag cleared by writing 0 or by reset
// - reading reset_cause_status clears all its flags
// - power-on sets power-on flag, clears the rest
// - one sticky flag per reset source, cleared by power-on or read
// - flags accumulate unless cleared between resets
// - monitor flag on monitor entry when both vector bytes are zero and interrupt pin high
// - 13-bit system counter, advanced on crystal clock
// - break request forces software interrupt vector fetch
module system_integration_unit (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    power_on,
  // register port
  input  wire logic [3:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [7:0]              rdata,
  // core side
  input  wire logic                    wait_exec,
  input  wire logic                    stop_exec,
  input  wire logic                    irq_request,
  input  wire logic                    break_request,
  input  wire logic                    break_active,
  // option register bits
  input  wire logic                    short_recovery_select,
  input  wire logic                    watchdog_disable,
  // reset sources and monitor entry
  input  wire sysint_pkg::reset_events_t reset_events,
  input  wire logic                    monitor_entry,
  input  wire logic [7:0]              vector_hi,
  input  wire logic [7:0]              vector_lo,
  input  wire logic                    irq_pin,
  // peripheral flag clear gating
  input  wire logic                    flag_clear_req,
  input  wire logic                    first_step_req,
  input  wire logic                    second_step_req,
  output logic                         flag_clear_ok,
  output logic                         second_step_ok,
  // power and clock controls
  output sysint_pkg::power_ctrl_t      power_ctrl,
  output logic [12:0]                  system_count
);

  typedef struct packed {
    sysint_pkg::power_state_t  pstate;
    logic [12:0]               count;
    logic [7:0]                cause;
    logic                      exit_flag;
    logic                      permit;
    logic                      step_armed;
    logic [7:0]                rdata;
    logic                      clear_ok;
    logic                      step_ok;
    sysint_pkg::power_ctrl_t   ctrl;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // recovery length from option bit
  function automatic logic [12:0] recovery_len(input logic short_sel);
    recovery_len = short_sel ? sysint_pkg::RECOVERY_SHORT
                             : sysint_pkg::RECOVERY_LONG;
  endfunction

  logic blocked;
  logic monitor_blank;

  always_comb begin
    state_next = state_reg;
    blocked = break_active && !state_reg.permit;
    monitor_blank = (vector_hi == sysint_pkg::ZERO_BYTE) &&
                    (vector_lo == sysint_pkg::ZERO_BYTE) && irq_pin;
    state_next.rdata = sysint_pkg::ZERO_BYTE;
    state_next.ctrl.clear_int_mask = 1'b0;
    state_next.ctrl.stack_start = 1'b0;
    state_next.ctrl.fetch_swi = break_request;

    // ---------------------------------------------------------------
    // flag protection
    // ---------------------------------------------------------------
    state_next.clear_ok = flag_clear_req && !blocked;
    if (first_step_req) begin
      state_next.step_armed = 1'b1;
    end
    state_next.step_ok = 1'b0;
    if (second_step_req && state_reg.step_armed && !blocked) begin
      state_next.step_ok = 1'b1;
      state_next.step_armed = 1'b0;
    end

    // ---------------------------------------------------------------
    // power state machine
    // ---------------------------------------------------------------
    case (state_reg.pstate)
      sysint_pkg::RUN: begin
        state_next.count = state_reg.count + sysint_pkg::COUNT_ONE;
        if (stop_exec) begin
          state_next.pstate = sysint_pkg::STOP_MODE;
          state_next.ctrl.clear_int_mask = 1'b1;
          state_next.count = '0;
        end else if (wait_exec) begin
          state_next.pstate = sysint_pkg::WAIT_MODE;
          state_next.ctrl.clear_int_mask = 1'b1;
        end
      end
      sysint_pkg::WAIT_MODE: begin
        state_next.count = state_reg.count + sysint_pkg::COUNT_ONE;
        if (break_request) begin
          state_next.pstate = sysint_pkg::RUN;
          state_next.exit_flag = 1'b1;
        end else if (irq_request) begin
          state_next.pstate = sysint_pkg::RUN;
          state_next.ctrl.stack_start = 1'b1;
        end
      end
      sysint_pkg::STOP_MODE: begin
        state_next.count = '0;
        if (break_request) begin
          state_next.exit_flag = 1'b1;
          state_next.pstate = sysint_pkg::STOP_RECOVER;
        end else if (irq_request) begin
          state_next.pstate = sysint_pkg::STOP_RECOVER;
        end
      end
      sysint_pkg::STOP_RECOVER: begin
        state_next.count = state_reg.count + sysint_pkg::COUNT_ONE;
        if (state_reg.count + sysint_pkg::COUNT_ONE >=
            recovery_len(short_recovery_select)) begin
          state_next.pstate = sysint_pkg::RUN;
          state_next.ctrl.stack_start = 1'b1;
        end
      end
      default: state_next.pstate = sysint_pkg::RUN;
    endcase

    // clock outputs follow the next state
    state_next.ctrl.cpu_clock_on = (state_next.pstate == sysint_pkg::RUN);
    state_next.ctrl.periph_clock_on =
      (state_next.pstate == sysint_pkg::RUN) ||
      (state_next.pstate == sysint_pkg::WAIT_MODE);
    state_next.ctrl.watchdog_run = !watchdog_disable &&
      (state_next.pstate != sysint_pkg::STOP_MODE);

    // ---------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------
    if (wr) begin
      if (addr == sysint_pkg::OFF_BREAK_EXIT_STATUS) begin
        if (!wdata[sysint_pkg::BIT_BREAK_EXIT] && !state_next.exit_flag) begin
          state_next.exit_flag = 1'b0;
        end
        if (!wdata[sysint_pkg::BIT_BREAK_EXIT] &&
            state_reg.pstate == state_next.pstate) begin
          state_next.exit_flag = 1'b0;
        end
      end else if (addr == sysint_pkg::OFF_BREAK_FLAG_CONTROL) begin
        state_next.permit = wdata[sysint_pkg::BIT_CLEAR_PERMIT];
      end
    end
    if (rd) begin
      if (addr == sysint_pkg::OFF_BREAK_EXIT_STATUS) begin
        state_next.rdata[sysint_pkg::BIT_BREAK_EXIT] = state_reg.exit_flag;
      end else if (addr == sysint_pkg::OFF_RESET_CAUSE_STATUS) begin
        state_next.rdata = state_reg.cause;
        state_next.cause = sysint_pkg::ZERO_BYTE;
      end else if (addr == sysint_pkg::OFF_BREAK_FLAG_CONTROL) begin
        state_next.rdata[sysint_pkg::BIT_CLEAR_PERMIT] = state_reg.permit;
      end
    end

    // ---------------------------------------------------------------
    // reset cause capture, set wins over read clear
    // ---------------------------------------------------------------
    if (reset_events.pin)        state_next.cause[sysint_pkg::RC_PIN] = 1'b1;
    if (reset_events.watchdog)   state_next.cause[sysint_pkg::RC_WATCHDOG] = 1'b1;
    if (reset_events.bad_opcode) state_next.cause[sysint_pkg::RC_BAD_OPCODE] = 1'b1;
    if (reset_events.bad_fetch)  state_next.cause[sysint_pkg::RC_BAD_FETCH] = 1'b1;
    if (reset_events.low_supply) state_next.cause[sysint_pkg::RC_LOW_SUPPLY] = 1'b1;
    if (reset_events.monitor_entry || (monitor_entry && monitor_blank)) begin
      state_next.cause[sysint_pkg::RC_MONITOR] = 1'b1;
    end

    // any reset source ends low-power modes and clears the exit flag
    if (|reset_events) begin
      state_next.pstate = sysint_pkg::RUN;
      state_next.exit_flag = 1'b0;
      state_next.ctrl.cpu_clock_on = 1'b1;
      state_next.ctrl.periph_clock_on = 1'b1;
      state_next.ctrl.watchdog_run = !watchdog_disable;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || power_on) begin
      state_reg <= '0;
      state_reg.cause <= power_on ? sysint_pkg::RESET_CAUSE_POR
                                  : state_next.cause;
      state_reg.ctrl.cpu_clock_on <= 1'b1;
      state_reg.ctrl.periph_clock_on <= 1'b1;
      state_reg.ctrl.watchdog_run <= !watchdog_disable;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata          = state_reg.rdata;
  assign flag_clear_ok  = state_reg.clear_ok;
  assign second_step_ok = state_reg.step_ok;
  assign power_ctrl     = state_reg.ctrl;
  assign system_count   = state_reg.count;

endmodule // system_integration_unit
`default_nettype wire

// ==== rtl/sysint_pkg.sv ====
// package: constants and carriers for the system integration unit block
package sysint_pkg;

  // register offsets (chosen; no documented map)
  localparam logic [3:0] OFF_BREAK_EXIT_STATUS  = 4'h0;
  localparam logic [3:0] OFF_RESET_CAUSE_STATUS = 4'h1;
  localparam logic [3:0] OFF_BREAK_FLAG_CONTROL = 4'h2;

  // field positions
  localparam int BIT_BREAK_EXIT   = 1;
  localparam int BIT_CLEAR_PERMIT = 0;
  localparam int RC_LOW_SUPPLY    = 1;
  localparam int RC_MONITOR       = 2;
  localparam int RC_BAD_FETCH     = 3;
  localparam int RC_BAD_OPCODE    = 4;
  localparam int RC_WATCHDOG      = 5;
  localparam int RC_PIN           = 6;
  localparam int RC_POWER_ON      = 7;

  // reset values
  localparam logic [7:0] RESET_CAUSE_POR = 8'h80;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;

  // stop recovery in crystal clock cycles
  localparam logic [12:0] RECOVERY_LONG  = 13'h1000;
  localparam logic [12:0] RECOVERY_SHORT = 13'h0020;
  localparam logic [12:0] COUNT_ONE      = 13'h0001;

  // monitor entry vector address pair
  localparam logic [15:0] VECTOR_HI_ADDR = 16'hFFFE;
  localparam logic [15:0] VECTOR_LO_ADDR = 16'hFFFF;

  typedef enum logic [1:0] {RUN, WAIT_MODE, STOP_MODE, STOP_RECOVER} power_state_t;

  // reset sources, one pulse each
  typedef struct packed {
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch;
    logic monitor_entry;
    logic low_supply;
  } reset_events_t;

  // low-power and clock controls toward core and clock generator
  typedef struct packed {
    logic cpu_clock_on;
    logic periph_clock_on;
    logic clear_int_mask;
    logic stack_start;
    logic watchdog_run;
    logic fetch_swi;
  } power_ctrl_t;

endpackage : sysint_pkg

// ==== tb/sysint_asserts.sv ====
// checker: port properties of the system integration unit
`timescale 1ns/1ps
`default_nettype none
module sysint_asserts (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      rst,
  input wire logic                      power_on,
  // watched ports
  input wire logic [3:0]                addr,
  input wire logic                      rd,
  input wire logic [7:0]                rdata,
  input wire logic                      wait_exec,
  input wire logic                      stop_exec,
  input wire logic                      irq_request,
  input wire logic                      short_recovery_select,
  input wire sysint_pkg::reset_events_t reset_events,
  input wire logic                      flag_clear_req,
  input wire logic                      break_active,
  input wire logic                      flag_clear_ok,
  input wire sysint_pkg::power_ctrl_t   power_ctrl,
  input wire logic [12:0]               system_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst || power_on);
  sequence rc_rd;
    rd && addr == sysint_pkg::OFF_RESET_CAUSE_STATUS && reset_events == '0;
  endsequence
  mask_clear_a: assert property ((wait_exec || stop_exec) |=> power_ctrl.clear_int_mask)
    else $error("mask clear missing");
  wait_clocks_a: assert property (wait_exec |=> !power_ctrl.cpu_clock_on && power_ctrl.periph_clock_on)
    else $error("wait clocks wrong");
  wait_wake_a: assert property (wait_exec ##1 irq_request |=> power_ctrl.stack_start)
    else $error("wait wake late");
  stop_clocks_a: assert property (stop_exec |=> !power_ctrl.cpu_clock_on && !power_ctrl.periph_clock_on)
    else $error("stop clocks on");
  count_hold_a: assert property (stop_exec |=> system_count == 13'h0000)
    else $error("counter not held");
  short_recover_a: assert property (short_recovery_select && stop_exec ##1 irq_request |=>
    !power_ctrl.stack_start [*8] ##[20:30] power_ctrl.stack_start) else $error("recovery wrong");
  clear_gate_a: assert property (flag_clear_req && !break_active |=> flag_clear_ok)
    else $error("clear blocked");
  read_clear_a: assert property (rc_rd ##1 rc_rd |=> rdata == 8'h00)
    else $error("cause not cleared");
  por_value_a: assert property ($fell(power_on) && rd && addr == sysint_pkg::OFF_RESET_CAUSE_STATUS |=>
    rdata == sysint_pkg::RESET_CAUSE_POR) else $error("power-on cause wrong");
  cover property (power_ctrl.stack_start);
  cover property (break_active && flag_clear_ok);
  cover property (stop_exec ##1 irq_request);
endmodule // sysint_asserts
bind system_integration_unit sysint_asserts chk_u (.clk(clk), .rst(rst), .power_on(power_on),
  .addr(addr), .rd(rd), .rdata(rdata), .wait_exec(wait_exec), .stop_exec(stop_exec),
  .irq_request(irq_request), .short_recovery_select(short_recovery_select),
  .reset_events(reset_events), .flag_clear_req(flag_clear_req), .break_active(break_active),
  .flag_clear_ok(flag_clear_ok), .power_ctrl(power_ctrl), .system_count(system_count));
`default_nettype wire

// ==== tb/core_model.sv ====
// model: processor core entering and leaving break state
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // break handshake
  input  wire logic fetch_swi,
  input  wire logic leave,
  output logic      break_active
);
  always @(posedge clk) begin
    if (rst) break_active <= 1'b0;
    else if (fetch_swi) break_active <= 1'b1;
    else if (leave) break_active <= 1'b0;
  end
endmodule // core_model
`default_nettype wire

// ==== tb/system_integration_unit_tb.sv ====
// testbench: system integration unit scenarios
`timescale 1ns/1ps
`default_nettype none
module system_integration_unit_tb;
  localparam logic [3:0] BX = sysint_pkg::OFF_BREAK_EXIT_STATUS;
  localparam logic [3:0] RC = sysint_pkg::OFF_RESET_CAUSE_STATUS;
  localparam logic [3:0] BF = sysint_pkg::OFF_BREAK_FLAG_CONTROL;
  logic clk = 0, rst = 1, power_on = 1, wr = 0, rd = 0, irq_request = 0, leave = 0;
  logic sr = 1, irq_pin = 1, break_active, flag_clear_ok, second_step_ok;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [6:0]  pl = '0;
  logic [12:0] system_count;
  sysint_pkg::reset_events_t ev = '0;
  sysint_pkg::power_ctrl_t   pc;
  int error_cnt = 0, checks = 0, n;
  always #10 clk = ~clk;
  system_integration_unit dut_u (.clk(clk), .rst(rst), .power_on(power_on), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wait_exec(pl[0]), .stop_exec(pl[1]),
    .irq_request(irq_request), .break_request(pl[2]), .break_active(break_active),
    .short_recovery_select(sr), .watchdog_disable(1'b0), .reset_events(ev),
    .monitor_entry(pl[6]), .vector_hi(8'h00), .vector_lo(8'h00), .irq_pin(irq_pin),
    .flag_clear_req(pl[3]), .first_step_req(pl[4]), .second_step_req(pl[5]),
    .flag_clear_ok(flag_clear_ok), .second_step_ok(second_step_ok), .power_ctrl(pc),
    .system_count(system_count));
  core_model core_u (.clk(clk), .rst(rst), .fetch_swi(pc.fetch_swi), .leave(leave),
    .break_active(break_active));
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge clk) pl <= m;
    @(posedge clk) pl <= '0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) rd <= 1'b1;
    addr <= a;
    @(posedge clk) rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic waitb(input bit sel);
    n = 0;
    while ((sel ? break_active : pc.stack_start) !== 1'b1) begin
      @(posedge clk) #1 n++;
      if (n > 5000) begin
        error_cnt++;
        tally_and_finish;
      end
    end
  endtask
  task automatic s_causes;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) ev <= 6'h01 << i;
      @(posedge clk) ev <= '0;
      rd_chk(RC, 8'h02 << i);
    end
    @(posedge clk) ev <= 6'h20;
    @(posedge clk) ev <= 6'h10;
    @(posedge clk) ev <= '0;
    rd_chk(RC, 8'h60);
    pulse(7'h40);
    rd_chk(RC, 8'h04);
    irq_pin <= 1'b0;
    pulse(7'h40);
    rd_chk(RC, 8'h00);
  endtask
  task automatic s_back_to_back;
    @(posedge clk) ev <= 6'h01;
    @(posedge clk) ev <= '0;
    rd <= 1'b1;
    addr <= RC;
    @(posedge clk) #1 chk("rdata", rdata, 8'h02);
    @(posedge clk) rd <= 1'b0;
    #1 chk("rdata", rdata, 8'h00);
  endtask
  task automatic s_wait;
    pulse(7'h01);
    irq_request <= 1'b1;
    #1 chk("clear_int_mask", pc.clear_int_mask, 1);
    chk("cpu_clock_on", pc.cpu_clock_on, 0);
    chk("periph_clock_on", pc.periph_clock_on, 1);
    chk("watchdog_run", pc.watchdog_run, 1);
    waitb(0);
    chk("wake_delay", n, 1);
    @(posedge clk) irq_request <= 1'b0;
  endtask
  task automatic s_stop(input logic s, input int len);
    sr <= s;
    pulse(7'h02);
    irq_request <= 1'b1;
    #1 chk("periph_clock_on", pc.periph_clock_on, 0);
    chk("system_count", system_count, 0);
    waitb(0);
    chk("recovery_in_range", n >= len - 2 && n <= len + 8, 1);
    @(posedge clk) irq_request <= 1'b0;
  endtask
  task automatic s_break;
    pulse(7'h10);
    pulse(7'h01);
    pulse(7'h04);
    waitb(1);
    rd_chk(BX, 8'h02);
    pulse(7'h08);
    #1 chk("flag_clear_ok", flag_clear_ok, 0);
    pulse(7'h20);
    #1 chk("second_step_ok", second_step_ok, 0);
    wr_reg(BF, 8'h01);
    pulse(7'h08);
    #1 chk("flag_clear_ok", flag_clear_ok, 1);
    wr_reg(BX, 8'h00);
    rd_chk(BX, 8'h00);
    @(posedge clk) leave <= 1'b1;
    @(posedge clk) leave <= 1'b0;
    pulse(7'h20);
    #1 chk("second_step_ok", second_step_ok, 1);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    power_on <= 1'b0;
    rd <= 1'b1;
    addr <= RC;
    @(posedge clk) rd <= 1'b0;
    #1 chk("rdata", rdata, sysint_pkg::RESET_CAUSE_POR);
    rd_chk(RC, 8'h00);
    rd_chk(4'hF, 8'h00);
    s_causes;
    s_back_to_back;
    s_wait;
    s_stop(1'b1, 32);
    s_stop(1'b0, 4096);
    s_break;
    tally_and_finish;
  end
endmodule // system_integration_unit_tb
`default_nettype wire
